/* File: shared/arsc_pkg.sv */
package arsc_pkg;

   typedef enum logic [1:0]
   {
      REF_EXT_PIN    = 2'b00,
      REF_SUPPLY_PIN = 2'b01,
      REF_DIG_SUPPLY = 2'b10,
      REF_FAST_INT   = 2'b11
   } arsc_ref_src_t;

   typedef enum logic [1:0]
   {
      GND_PIN        = 2'b00,
      GND_ANALOG_PIN = 2'b01,
      GND_CHIP       = 2'b10
   } arsc_gnd_src_t;

   typedef enum logic [1:0]
   {
      PHASE_IDLE     = 2'b00,
      PHASE_TRACK    = 2'b01,
      PHASE_CONVERT  = 2'b10
   } arsc_phase_t;

   typedef struct packed
   {
      arsc_phase_t phase;
      logic        temp_selected;
   } arsc_conv_status_t;

   typedef struct packed
   {
      arsc_ref_src_t ref_src;
      arsc_gnd_src_t gnd_src;
      logic          fast_ref_on;
      logic          sensor_enable;
   } arsc_conv_ctrl_t;

endpackage

/* File: shared/arsc_regs.svh */
`ifndef ARSC_REGS_SVH
`define ARSC_REGS_SVH

// Register pages and addresses
`define ARSC_PAGE_OFFSET      4'hf
`define ARSC_ADDR_OFFSET_HIGH 8'h8e
`define ARSC_ADDR_OFFSET_LOW  8'h8d
`define ARSC_PAGE_REFCTL      4'h0
`define ARSC_ADDR_REFCTL      8'hd3

// Reference control layout
`define ARSC_REFCTL_RESET     8'h18
`define ARSC_REFCTL_WMASK     8'h3c
`define ARSC_GND_BIT          5
`define ARSC_REFSEL_MSB       4
`define ARSC_REFSEL_LSB       3
`define ARSC_SENSOR_BIT       2

// Offset layout
`define ARSC_OFFSET_WIDTH     10
`define ARSC_LOW_UNUSED       6'h00

`endif

/* File: sim/test_arsc_reference_control.sv */
`timescale 1ns/1ps
`include "arsc_regs.svh"

module test_arsc_reference_control;

   logic                            clk;
   logic                            resetn;
   logic [3:0]                      sfr_page;
   logic [7:0]                      sfr_addr;
   logic [7:0]                      sfr_wdata;
   logic                            sfr_wr;
   logic                            sfr_rd;
   logic [7:0]                      sfr_rdata;
   logic                            fuse_load;
   logic [9:0]                      fuse_value;
   arsc_pkg::arsc_conv_status_t     conv_status;
   arsc_pkg::arsc_conv_ctrl_t       conv_ctrl;
   integer                          bad_count;
   integer                          n_tests;
   logic [7:0]                      d;

   arsc_reference_control u_arsc_reference_control
   (
      .clk         (clk),
      .resetn      (resetn),
      .sfr_page    (sfr_page),
      .sfr_addr    (sfr_addr),
      .sfr_wdata   (sfr_wdata),
      .sfr_wr      (sfr_wr),
      .sfr_rd      (sfr_rd),
      .sfr_rdata   (sfr_rdata),
      .fuse_load   (fuse_load),
      .fuse_value  (fuse_value),
      .conv_status (conv_status),
      .conv_ctrl   (conv_ctrl)
   );

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task results;
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      sfr_wr    <= 1'b1;
      sfr_page  <= pg;
      sfr_addr  <= a;
      sfr_wdata <= v;
      @(posedge clk);
      sfr_wr    <= 1'b0;
   endtask

   task rd(input logic [3:0] pg, input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      sfr_rd   <= 1'b1;
      sfr_page <= pg;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd   <= 1'b0;
      #1;
      v = sfr_rdata;
   endtask

   task set_status(input logic [1:0] ph, input logic t);
      @(posedge clk);
      conv_status <= arsc_pkg::arsc_conv_status_t'({ph, t});
      @(posedge clk);
      @(posedge clk);
      #1;
   endtask

   task pulse_reset;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
   endtask

   // Expected converter controls from register value and phase
   function automatic logic [7:0] exp_ctrl(input logic [7:0] r, input logic [1:0] ph,
                                           input logic t);
      logic [1:0] g;
      logic       f;
      g = {1'b0, r[5]};
      if ((ph == arsc_pkg::PHASE_CONVERT && r[4:3] == 2'b11) ||
          (ph == arsc_pkg::PHASE_TRACK && t))
      begin
         g = 2'b10;
      end
      f = (r[4:3] == 2'b11) && (ph == arsc_pkg::PHASE_TRACK || ph == arsc_pkg::PHASE_CONVERT);
      return {2'b00, r[4:3], g, f, r[2]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task test_reset;
      rd(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, d);
      chk(d, 8'h18, "ctrl reset");
      chk({2'b00, conv_ctrl}, exp_ctrl(8'h18, 2'b00, 1'b0), "ctrl outs reset");
   endtask

   task test_offset;
      logic [9:0] ov;
      ov = 10'h2b5;
      @(posedge clk);
      fuse_load  <= 1'b1;
      fuse_value <= ov;
      @(posedge clk);
      fuse_load  <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         rd(`ARSC_PAGE_OFFSET, `ARSC_ADDR_OFFSET_HIGH, d);
         chk(d, ov[9:2], "offset high");
         rd(`ARSC_PAGE_OFFSET, `ARSC_ADDR_OFFSET_LOW, d);
         chk(d, {ov[1:0], 6'h00}, "offset low");
         // Pass 1 tries to overwrite, pass 2 applies a reset whose survival pass 3 checks
         if (k == 0)
         begin
            wr(`ARSC_PAGE_OFFSET, `ARSC_ADDR_OFFSET_HIGH, 8'h52);
            wr(`ARSC_PAGE_OFFSET, `ARSC_ADDR_OFFSET_LOW, 8'hff);
         end
         if (k == 1)
         begin
            pulse_reset();
         end
      end
   endtask

   task test_unused_bits;
      wr(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, 8'hff);
      rd(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, d);
      chk(d, 8'h3c, "ctrl unused ones");
      wr(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, 8'hc3);
      rd(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, d);
      chk(d, 8'h00, "ctrl unused only");
   endtask

   task test_routing;
      logic [7:0] r;
      for (int c = 0; c < 8; c++)
      begin
         r = {2'b00, c[0], c[2:1], ~c[0], 2'b00};
         wr(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, r);
         // Phase code 11 is unused and must behave as idle
         for (int p = 0; p < 4; p++)
         begin
            for (int t = 0; t < 2; t++)
            begin
               set_status(p[1:0], t[0]);
               chk({2'b00, conv_ctrl}, exp_ctrl(r, p[1:0], t[0]), "routing");
               // Same compare covers ground, overrides, fast reference and sensor enable
            end
         end
      end
   endtask

   task test_pages;
      wr(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, 8'h08);
      wr(4'h1, `ARSC_ADDR_REFCTL, 8'h3c);
      rd(`ARSC_PAGE_REFCTL, `ARSC_ADDR_REFCTL, d);
      chk(d, 8'h08, "wrong page write");
      rd(`ARSC_PAGE_OFFSET, `ARSC_ADDR_REFCTL, d);
      chk(d, 8'h00, "wrong page read");
      rd(`ARSC_PAGE_REFCTL, `ARSC_ADDR_OFFSET_HIGH, d);
      chk(d, 8'h00, "offset wrong page");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk         = 1'b0;
      resetn      = 1'b0;
      sfr_page    = 4'h0;
      sfr_addr    = 8'h00;
      sfr_wdata   = 8'h00;
      sfr_wr      = 1'b0;
      sfr_rd      = 1'b0;
      fuse_load   = 1'b0;
      fuse_value  = 10'h000;
      conv_status = '0;
      bad_count   = 0;
      n_tests     = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      test_reset();
      test_offset();
      test_reset();
      test_unused_bits();
      test_routing();
      test_pages();
      results();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      results();
   end

endmodule

/* File: verilog/arsc_offset_store.sv */
`timescale 1ns/1ps
`include "arsc_regs.svh"

module arsc_offset_store
#(
   parameter int WIDTH = `ARSC_OFFSET_WIDTH
)
(
   input  wire logic             clk,         // System clock
   input  wire logic             fuse_load,   // Pulse: take factory value
   input  wire logic [WIDTH-1:0] fuse_value,  // Factory trim word
   output logic      [WIDTH-1:0] offset       // Stored sensor offset
);

   logic [WIDTH-1:0] next_offset;

   always_comb
   begin
      next_offset = offset;
      if (fuse_load)
      begin
         next_offset = fuse_value;
      end
   end

   // No reset on purpose: the trim value survives a device reset
   always_ff @(posedge clk)
   begin
      offset <= next_offset;
   end

endmodule

/* File: verilog/arsc_reference_control.sv */
// Operation
// RULE_01 - A read-only high byte at page 0xF address 0x8E returns offset bits 9 to 2.
// RULE_02 - A read-only low byte at 0x8D returns offset bits 1 and 0 in bits 7:6, zeros below.
// RULE_03 - Field 4:3 routes external pin, supply pin, 1.8 V supply or 1.65 V fast reference.
// RULE_04 - With code 11 the fast reference is switched on only while a conversion needs it.
// RULE_05 - Bit 5 picks the ground pin (0) or analog ground pin (1) for tracking and conversion.
// RULE_06 - Sampling the temperature sensor always uses chip ground, overriding bit 5.
// RULE_07 - With the fast reference selected, conversion always uses chip ground.
// RULE_08 - Bit 2 enables the temperature sensor; cleared, the sensor output floats.
// RULE_09 - Bits 7:6 and 1:0 of reference control read as zero and ignore writes.
// RULE_10 - Reference control sits at page 0x0 address 0xD3 and resets to fast reference.
// RULE_11 - The offset holds a factory sensor measurement and keeps it across resets.
// RULE_12 - Writes to the offset bytes never change the stored offset.
`timescale 1ns/1ps
`include "arsc_regs.svh"

module arsc_reference_control
#(
   parameter int OFFSET_WIDTH = `ARSC_OFFSET_WIDTH
)
(
   input  wire logic                        clk,         // System clock, 20 MHz
   input  wire logic                        resetn,      // Async reset, active low
   input  wire logic [3:0]                  sfr_page,    // Register page
   input  wire logic [7:0]                  sfr_addr,    // Register address
   input  wire logic [7:0]                  sfr_wdata,   // Write data
   input  wire logic                        sfr_wr,      // Write strobe
   input  wire logic                        sfr_rd,      // Read strobe
   output logic      [7:0]                  sfr_rdata,   // Read data, registered
   input  wire logic                        fuse_load,   // Factory value load pulse
   input  wire logic [OFFSET_WIDTH-1:0]     fuse_value,  // Factory offset word
   input  wire arsc_pkg::arsc_conv_status_t conv_status, // Converter phase and input
   output arsc_pkg::arsc_conv_ctrl_t        conv_ctrl    // Reference, ground, enables
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic [OFFSET_WIDTH-1:0] offset;
   logic                    hit_high;
   logic                    hit_low;
   logic                    hit_refctl;

   always_comb
   begin
      hit_high   = (sfr_page == `ARSC_PAGE_OFFSET) && (sfr_addr == `ARSC_ADDR_OFFSET_HIGH);
      hit_low    = (sfr_page == `ARSC_PAGE_OFFSET) && (sfr_addr == `ARSC_ADDR_OFFSET_LOW);
      hit_refctl = (sfr_page == `ARSC_PAGE_REFCTL) && (sfr_addr == `ARSC_ADDR_REFCTL);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Factory offset

   // Store has no write path from the bus at all
   arsc_offset_store
   #(
      .WIDTH      (OFFSET_WIDTH)
   )
   u_offset_store
   (
      .clk        (clk),
      .fuse_load  (fuse_load),   // see RULE_11
      .fuse_value (fuse_value),  // see RULE_12
      .offset     (offset)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Reference control register

   logic [7:0] reference_control;
   logic [7:0] next_reference_control;

   always_comb
   begin
      next_reference_control = reference_control;
      if (sfr_wr && hit_refctl)
      begin
         // Unused bits forced low
         next_reference_control = sfr_wdata & `ARSC_REFCTL_WMASK; // see RULE_09
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reference_control <= `ARSC_REFCTL_RESET; // see RULE_10
      end
      else
      begin
         reference_control <= next_reference_control;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [7:0] next_sfr_rdata;

   always_comb
   begin
      next_sfr_rdata = sfr_rdata;
      if (sfr_rd)
      begin
         if (hit_high)
         begin
            next_sfr_rdata = offset[OFFSET_WIDTH-1:OFFSET_WIDTH-8]; // see RULE_01
         end
         else if (hit_low)
         begin
            next_sfr_rdata = {offset[1:0], `ARSC_LOW_UNUSED}; // see RULE_02
         end
         else if (hit_refctl)
         begin
            next_sfr_rdata = reference_control;
         end
         else
         begin
            next_sfr_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sfr_rdata <= 8'h00;
      end
      else
      begin
         sfr_rdata <= next_sfr_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Converter side

   arsc_pkg::arsc_ref_src_t   sel_ref;
   logic                      sel_analog_gnd;
   arsc_pkg::arsc_conv_ctrl_t next_conv_ctrl;

   always_comb
   begin
      sel_ref        = arsc_pkg::arsc_ref_src_t'(
                          reference_control[`ARSC_REFSEL_MSB:`ARSC_REFSEL_LSB]);
      sel_analog_gnd = reference_control[`ARSC_GND_BIT];

      next_conv_ctrl               = conv_ctrl;
      next_conv_ctrl.ref_src       = sel_ref; // see RULE_03
      next_conv_ctrl.sensor_enable = reference_control[`ARSC_SENSOR_BIT]; // see RULE_08

      // Fast reference powered only while tracking or converting
      // Unused phase code counts as idle, so the buffer stays off
      next_conv_ctrl.fast_ref_on = (sel_ref == arsc_pkg::REF_FAST_INT)
         && ((conv_status.phase == arsc_pkg::PHASE_TRACK)
             || (conv_status.phase == arsc_pkg::PHASE_CONVERT)); // see RULE_04

      unique case (conv_status.phase)
         arsc_pkg::PHASE_TRACK:
         begin
            if (conv_status.temp_selected)
            begin
               next_conv_ctrl.gnd_src = arsc_pkg::GND_CHIP; // see RULE_06
            end
            else
            begin
               next_conv_ctrl.gnd_src = sel_analog_gnd ? arsc_pkg::GND_ANALOG_PIN
                                                       : arsc_pkg::GND_PIN; // see RULE_05
            end
         end
         arsc_pkg::PHASE_CONVERT:
         begin
            if (sel_ref == arsc_pkg::REF_FAST_INT)
            begin
               next_conv_ctrl.gnd_src = arsc_pkg::GND_CHIP; // see RULE_07
            end
            else
            begin
               next_conv_ctrl.gnd_src = sel_analog_gnd ? arsc_pkg::GND_ANALOG_PIN
                                                       : arsc_pkg::GND_PIN; // see RULE_05
            end
         end
         default:
         begin
            // Idle and the unused phase code both fall back to the chosen pin
            next_conv_ctrl.gnd_src = sel_analog_gnd ? arsc_pkg::GND_ANALOG_PIN
                                                    : arsc_pkg::GND_PIN; // see RULE_05
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         conv_ctrl.ref_src       <= arsc_pkg::REF_FAST_INT;
         conv_ctrl.gnd_src       <= arsc_pkg::GND_PIN;
         conv_ctrl.fast_ref_on   <= 1'b0;
         conv_ctrl.sensor_enable <= 1'b0;
      end
      else
      begin
         conv_ctrl <= next_conv_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   logic first_cycle;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         first_cycle <= 1'b1;
      end
      else
      begin
         first_cycle <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!resetn);

   sequence seq_refctl_write;
      sfr_wr && hit_refctl;
   endsequence

   sequence seq_offset_write;
      sfr_wr && (hit_high || hit_low);
   endsequence

   sequence seq_refctl_read;
      sfr_rd && hit_refctl;
   endsequence

   a_high_byte_read: assert property ( // see RULE_01
      sfr_rd && hit_high |=> sfr_rdata == $past(offset[OFFSET_WIDTH-1:OFFSET_WIDTH-8]))
      else $error("High offset byte read wrong");

   a_low_byte_read: assert property ( // see RULE_02
      sfr_rd && hit_low |=> (sfr_rdata[7:6] == $past(offset[1:0])) && (sfr_rdata[5:0] == 6'h00))
      else $error("Low offset byte read wrong");

   a_ref_route: assert property ( // see RULE_03
      seq_refctl_write ##1 !(sfr_wr && hit_refctl)
      |=> conv_ctrl.ref_src == $past(sfr_wdata[`ARSC_REFSEL_MSB:`ARSC_REFSEL_LSB], 2))
      else $error("Reference source not routed");

   a_fast_ref_gate: assert property ( // see RULE_04
      conv_ctrl.fast_ref_on |-> ($past(conv_status.phase) == arsc_pkg::PHASE_TRACK
                                 || $past(conv_status.phase) == arsc_pkg::PHASE_CONVERT)
                                && $past(sel_ref) == arsc_pkg::REF_FAST_INT)
      else $error("Fast reference on without need");

   a_fast_ref_idle: assert property ( // see RULE_04
      conv_status.phase != arsc_pkg::PHASE_TRACK && conv_status.phase != arsc_pkg::PHASE_CONVERT
      |=> !conv_ctrl.fast_ref_on)
      else $error("Fast reference on outside conversion");

   a_ground_choice: assert property ( // see RULE_05
      conv_status.phase == arsc_pkg::PHASE_IDLE && sel_analog_gnd
      |=> conv_ctrl.gnd_src == arsc_pkg::GND_ANALOG_PIN)
      else $error("Analog ground pin not chosen");

   a_sensor_ground: assert property ( // see RULE_06
      conv_status.phase == arsc_pkg::PHASE_TRACK && conv_status.temp_selected
      |=> conv_ctrl.gnd_src == arsc_pkg::GND_CHIP)
      else $error("Sensor sampling not on chip ground");

   a_fast_ref_ground: assert property ( // see RULE_07
      conv_status.phase == arsc_pkg::PHASE_CONVERT && sel_ref == arsc_pkg::REF_FAST_INT
      |=> conv_ctrl.gnd_src == arsc_pkg::GND_CHIP && conv_ctrl.fast_ref_on)
      else $error("Fast reference conversion not on chip ground");

   a_sensor_enable: assert property ( // see RULE_08
      seq_refctl_write ##1 !(sfr_wr && hit_refctl)
      |=> conv_ctrl.sensor_enable == $past(sfr_wdata[`ARSC_SENSOR_BIT], 2))
      else $error("Sensor enable does not follow write");

   a_unused_bits: assert property ( // see RULE_09
      seq_refctl_read |=> sfr_rdata[7:6] == 2'b00 && sfr_rdata[1:0] == 2'b00)
      else $error("Unused control bits not zero");

   a_reset_value: assert property ( // see RULE_10
      first_cycle |-> reference_control == `ARSC_REFCTL_RESET
                      && conv_ctrl.ref_src == arsc_pkg::REF_FAST_INT
                      && conv_ctrl.gnd_src == arsc_pkg::GND_PIN
                      && !conv_ctrl.sensor_enable)
      else $error("Reset value of control wrong");

   a_offset_kept: assert property ( // see RULE_12
      seq_offset_write and (!fuse_load) |=> $stable(offset))
      else $error("Offset changed by bus write");

   a_refctl_page: assert property ( // see RULE_10
      sfr_wr && !hit_refctl |=> $stable(reference_control))
      else $error("Control changed by foreign write");

endmodule
